// *** common/ps_seq_consts.svh ***
// Purpose: constants for the passive serial configuration sequencer
// Assumes: clk is the internal oscillator domain (25 MHz in the bench)
// Notes: times kept in their printed units, cycle counts derived
`ifndef PS_SEQ_CONSTS_SVH
`define PS_SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 40
`define POR_TIME_MS 100
`define POR_CYCLES ((`POR_TIME_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_USR_CYCLES 299
`define INIT_OSC_TIME_US 18
`define INIT_OSC_CYCLES ((`INIT_OSC_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STREAM_BITS 1024
`define OPT_INIT_DONE_BIT 0
`define OPT_USR_CLK_BIT 1
`endif

// *** common/ps_seq_pkg.sv ***
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes: one-hot stage codes
package ps_seq_pkg;
    typedef enum logic [5:0] {
        ST_POR = 6'h01,
        ST_RESET = 6'h02,
        ST_WAIT_STATUS = 6'h04,
        ST_LOAD = 6'h08,
        ST_INIT = 6'h10,
        ST_USER = 6'h20
    } stage_t;
endpackage

// *** rtl/ps_load_shift.sv ***
// Purpose: link clock side: captures the option bits and counts the stream
// Assumes: dclk stops outside frames; arm rises well before the first dclk
// Notes: all results are levels, resynchronised by the consumer
`timescale 1ns/1ns
`default_nettype none
`include "ps_seq_consts.svh"
module ps_load_shift #(
    parameter int STREAM_BITS = `STREAM_BITS
) (
    input wire logic dclk,
    input wire logic arm,
    input wire logic serial_load_data,
    output logic loaded,
    output logic [1:0] options
);
    localparam int CW = $clog2(STREAM_BITS + 1);
    logic [CW-1:0] count, next_count;
    logic [1:0] next_options;
    logic next_loaded;
    initial begin
        if (STREAM_BITS < 4) $error("stream too short");
    end
    //////////////////////////////////////////////////////////////////
    // count bits and keep the option bits of the first frame
    always_comb begin
        next_count = count;
        next_options = options;
        next_loaded = loaded;
        // arm is an async clear; a gate synchronised on dclk would eat bits
        if (!loaded) begin
            next_count = CW'(count + 1'b1);
            if (count == CW'(`OPT_INIT_DONE_BIT))
                next_options[0] = serial_load_data;
            if (count == CW'(`OPT_USR_CLK_BIT))
                next_options[1] = serial_load_data;
            if (count == CW'(STREAM_BITS - 1))
                next_loaded = 1'b1;
        end
    end
    // bits sampled on rising dclk
    always_ff @(posedge dclk or negedge arm) begin
        if (!arm) begin
            count <= '0;
            options <= 2'h0;
            loaded <= 1'b0;
        end else begin
            count <= next_count;
            options <= next_options;
            loaded <= next_loaded;
        end
    end
endmodule
`default_nettype wire

// *** rtl/ps_config_seq.sv ***
// Purpose: configuration sequencer for passive serial loading
// Assumes: clk is the internal oscillator; pins are open drain, oe low drives
// Notes: a stalled start-up clock stalls entry to user mode
`timescale 1ns/1ns
`default_nettype none
`include "ps_seq_consts.svh"
module ps_config_seq
    import ps_seq_pkg::*;
#(
    parameter int POR_CYCLES = `POR_CYCLES,
    parameter int INIT_OSC_CYCLES = `INIT_OSC_CYCLES,
    parameter int INIT_USR_CYCLES = `INIT_USR_CYCLES,
    parameter int STREAM_BITS = `STREAM_BITS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic dclk,
    input wire logic serial_load_data,
    input wire logic config_req_n_in,
    input wire logic status_n_in,
    output logic status_n_out,
    output logic status_n_oe_n,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe_n,
    input wire logic start_clk_in,
    output logic init_done_out,
    output logic init_done_oe_n,
    output logic user_io_hiz,
    output logic user_io_pullup,
    output logic user_mode,
    output ps_seq_pkg::stage_t stage
);
    import ps_seq_pkg::*;
    localparam int PW = $clog2(POR_CYCLES + 1);
    localparam int IW = $clog2(INIT_OSC_CYCLES + INIT_USR_CYCLES + 2);
    initial begin
        if (POR_CYCLES < 1 || INIT_OSC_CYCLES < 1 || INIT_USR_CYCLES < 1)
            $error("counts must be at least one");
    end
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [3:0] sync_a, sync_b;
    logic [3:0] raw;
    assign raw = {start_clk_in, done_in, status_n_in, config_req_n_in};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_a <= 4'hF;
            sync_b <= 4'hF;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end
    logic req_s, status_s, done_s, uclk_s;
    assign req_s = sync_b[0];
    assign status_s = sync_b[1];
    assign done_s = sync_b[2];
    assign uclk_s = sync_b[3];
    // link side loader; its level results cross back below
    logic arm;
    logic loaded_l;
    logic [1:0] opt_l;
    ps_load_shift #(.STREAM_BITS(STREAM_BITS)) u_shift (
        .dclk(dclk),
        .arm(arm),
        .serial_load_data(serial_load_data),
        .loaded(loaded_l),
        .options(opt_l)
    );
    logic [2:0] ld_a, ld_b;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ld_a <= 3'h0;
            ld_b <= 3'h0;
        end else begin
            ld_a <= {opt_l, loaded_l};
            ld_b <= ld_a;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // sequencer state
    stage_t next_stage;
    logic [PW-1:0] por_cnt, next_por_cnt;
    logic [IW-1:0] init_cnt, next_init_cnt;
    logic req_d, next_req_d;
    logic done_d, next_done_d;
    logic uclk_d, next_uclk_d;
    logic use_uclk, next_use_uclk;
    logic use_idone, next_use_idone;
    logic next_arm;
    logic next_status_oe_n, next_done_oe_n, next_idone_oe_n;
    logic next_hiz, next_pullup, next_user;
    // next stage and pin controls
    always_comb begin
        next_stage = stage;
        next_por_cnt = por_cnt;
        next_init_cnt = init_cnt;
        next_req_d = req_s;
        next_done_d = done_s;
        next_uclk_d = uclk_s;
        next_use_uclk = use_uclk;
        next_use_idone = use_idone;
        case (stage)
            ST_POR: begin
                if (por_cnt == PW'(POR_CYCLES - 1)) begin
                    next_stage = ST_RESET;
                    // a request already high counts as a rising edge
                    next_req_d = 1'b0;
                end
                else
                    next_por_cnt = PW'(por_cnt + 1'b1);
            end
            ST_RESET: begin
                // request low holds reset; rising edge leaves it
                if (req_s && !req_d)
                    next_stage = ST_WAIT_STATUS;
                else if (req_s && status_s)
                    next_stage = ST_WAIT_STATUS;
            end
            ST_WAIT_STATUS: begin
                if (!req_s)
                    next_stage = ST_RESET;
                else if (status_s)
                    next_stage = ST_LOAD;
            end
            ST_LOAD: begin
                if (!req_s || !status_s)
                    next_stage = ST_RESET;
                else if (done_s && !done_d) begin
                    // shared done rise starts initialization
                    next_stage = ST_INIT;
                    next_init_cnt = '0;
                    next_use_idone = ld_b[1];
                    next_use_uclk = ld_b[2];
                end
            end
            ST_INIT: begin
                if (!req_s)
                    next_stage = ST_RESET;
                else if (use_uclk) begin
                    // count start-up clock rises
                    if (uclk_s && !uclk_d)
                        next_init_cnt = IW'(init_cnt + 1'b1);
                    if (init_cnt == IW'(INIT_USR_CYCLES))
                        next_stage = ST_USER;
                end else begin
                    next_init_cnt = IW'(init_cnt + 1'b1);
                    if (init_cnt == IW'(INIT_OSC_CYCLES - 1))
                        next_stage = ST_USER;
                end
            end
            ST_USER: begin
                if (!req_s)
                    next_stage = ST_RESET;
            end
            default: next_stage = ST_POR;
        endcase
        // outputs follow the next stage so they settle with it
        next_status_oe_n = !(next_stage == ST_POR || next_stage == ST_RESET);
        next_done_oe_n = !(next_stage == ST_POR || next_stage == ST_RESET
                           || next_stage == ST_WAIT_STATUS
                           || (next_stage == ST_LOAD && !ld_b[0]));
        next_idone_oe_n = !(next_use_idone && next_stage == ST_INIT);
        next_hiz = (next_stage != ST_USER);
        next_pullup = (next_stage != ST_USER) && (next_stage != ST_POR);
        next_user = (next_stage == ST_USER);
        next_arm = (next_stage == ST_LOAD);
    end
    // register everything; pin drive values are constant low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage <= ST_POR;
            por_cnt <= '0;
            init_cnt <= '0;
            req_d <= 1'b1;
            done_d <= 1'b1;
            uclk_d <= 1'b0;
            use_uclk <= 1'b0;
            use_idone <= 1'b0;
            arm <= 1'b0;
            status_n_oe_n <= 1'b0;
            done_oe_n <= 1'b0;
            init_done_oe_n <= 1'b1;
            user_io_hiz <= 1'b1;
            user_io_pullup <= 1'b0;
            user_mode <= 1'b0;
            status_n_out <= 1'b0;
            done_out <= 1'b0;
            init_done_out <= 1'b0;
        end else begin
            stage <= next_stage;
            por_cnt <= next_por_cnt;
            init_cnt <= next_init_cnt;
            req_d <= next_req_d;
            done_d <= next_done_d;
            uclk_d <= next_uclk_d;
            use_uclk <= next_use_uclk;
            use_idone <= next_use_idone;
            arm <= next_arm;
            status_n_oe_n <= next_status_oe_n;
            done_oe_n <= next_done_oe_n;
            init_done_oe_n <= next_idone_oe_n;
            user_io_hiz <= next_hiz;
            user_io_pullup <= next_pullup;
            user_mode <= next_user;
            status_n_out <= 1'b0;
            done_out <= 1'b0;
            init_done_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** test/cfg_mem_model.sv ***
// Purpose: serial configuration memory model for the far side
// Assumes: oe is the shared status wire, ncs the done wire
// Notes: serial clock stands still outside frames
`timescale 1ns/1ns
`default_nettype none
module cfg_mem_model #(
    parameter int BITS = 16
) (
    input wire logic oe,
    input wire logic ncs,
    input wire logic [BITS-1:0] image,
    output logic dclk,
    output logic data,
    output logic oe_pull_n
);
    int i;
    // own power-on delay holds the enable line low
    initial begin
        dclk = 1'b0;
        data = 1'b1;
        oe_pull_n = 1'b0;
        #1500 oe_pull_n = 1'b1;
    end
    // one frame per rising enable, cut short by losing enable or select
    always @(posedge oe) begin
        #1013;
        for (i = 0; i < BITS && oe && !ncs; i++) begin
            data = image[i];
            #40 dclk = 1'b1;
            #40 dclk = 1'b0;
            data = ~data; // hold time over, show no stale bit
        end
        data = 1'b1;
    end
endmodule
`default_nettype wire

// *** test/ps_config_seq_asserts.sv ***
// Purpose: concurrent checks on the sequencer ports
// Assumes: all checks in the clk domain
// Notes: pins pass two sync flops before use
`timescale 1ns/1ns
`default_nettype none
module ps_config_seq_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic config_req_n_in,
    input wire logic status_n_in,
    input wire logic done_in,
    input wire logic status_n_oe_n,
    input wire logic done_oe_n,
    input wire logic init_done_oe_n,
    input wire logic user_io_hiz,
    input wire logic user_io_pullup,
    input wire logic user_mode,
    input wire ps_seq_pkg::stage_t stage
);
    import ps_seq_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////
    a_por_lines_low: assert property (
        stage == ST_POR |-> !status_n_oe_n && !done_oe_n && user_io_hiz)
        else $error("lines not held in power-on");
    a_request_holds_reset: assert property (
        !config_req_n_in [*5] |-> !status_n_oe_n && !done_oe_n && user_io_hiz && !user_mode)
        else $error("request low did not reset");
    a_load_pullups_on: assert property (
        stage == ST_LOAD && $past(stage) == ST_LOAD |-> user_io_pullup && user_io_hiz)
        else $error("pull-ups off while loading");
    a_user_pins_free: assert property (
        stage == ST_USER && $past(stage) == ST_USER
        |-> user_mode && !user_io_hiz && !user_io_pullup && init_done_oe_n)
        else $error("user mode outputs wrong");
    a_load_after_status: assert property (
        $rose(stage == ST_LOAD) |-> $past(status_n_in, 2) && $past(config_req_n_in, 2))
        else $error("loading began without status high");
    a_init_after_done: assert property (
        $rose(stage == ST_INIT) |-> $past(done_in, 2) && $past(done_oe_n))
        else $error("init began without done high");
    a_stage_order: assert property (
        $changed(stage) |-> stage == ST_RESET || stage == ($past(stage) << 1))
        else $error("stage order broken");
    a_done_free_init: assert property (
        stage == ST_INIT |-> done_oe_n)
        else $error("done pulled low during init");
endmodule
bind ps_config_seq ps_config_seq_asserts u_asserts (
    .clk, .nrst, .config_req_n_in, .status_n_in, .done_in, .status_n_oe_n, .done_oe_n,
    .init_done_oe_n, .user_io_hiz, .user_io_pullup, .user_mode, .stage);
`default_nettype wire

// *** test/ps_config_seq_tb_top.sv ***
// Purpose: bench for the configuration sequencer
// Assumes: open-drain wires resolved here with pull-ups
// Notes: short power-on and oscillator init counts; start-up clock init count left at default
`timescale 1ns/1ns
`default_nettype none
module ps_config_seq_tb_top;
    import ps_seq_pkg::*;
    localparam int OSC = 8;
    logic clk, nrst, config_req_n_in, start_clk_in, hold_n;
    logic dclk, serial_load_data, mem_pull_n, status_w, done_w, init_w;
    logic status_n_out, status_n_oe_n, done_out, done_oe_n, init_done_out, init_done_oe_n;
    logic user_io_hiz, user_io_pullup, user_mode;
    logic [15:0] image;
    stage_t stage;
    int failures, compares;
    // wired-and of every party on each pulled-up line
    assign status_w = (status_n_oe_n | status_n_out) & mem_pull_n & hold_n;
    assign done_w = done_oe_n | done_out; // bench never pulls done low
    assign init_w = init_done_oe_n | init_done_out;
    ps_config_seq #(.POR_CYCLES(20), .INIT_OSC_CYCLES(OSC), .STREAM_BITS(16)) u_dut (
        .clk, .nrst, .dclk, .serial_load_data, .config_req_n_in, .status_n_in(status_w),
        .status_n_out, .status_n_oe_n, .done_in(done_w), .done_out, .done_oe_n, .start_clk_in,
        .init_done_out, .init_done_oe_n, .user_io_hiz, .user_io_pullup, .user_mode, .stage);
    cfg_mem_model #(.BITS(16)) u_mem (.oe(status_w), .ncs(done_w), .image, .dclk,
        .data(serial_load_data), .oe_pull_n(mem_pull_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_stage(input stage_t exp);
        compares++;
        if (stage !== exp) begin
            failures++;
            $display("wrong value stage expected %h seen %h", exp, stage);
        end
    endtask
    // bounded wait; a miss ends the run
    task automatic wait_stage(input stage_t s, input int lim);
        int n;
        n = 0;
        while (stage !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        check_stage(s);
        if (stage !== s) wrap_up();
    endtask
    // start-up clock pulses, driven only while the bench wants them
    task automatic pulse_start(input int k);
        repeat (k) begin
            @(posedge clk) start_clk_in <= 1'b1;
            repeat (3) @(posedge clk);
            start_clk_in <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // power-on hold, then release and entry to loading
    task automatic power_up();
        repeat (5) @(negedge clk);
        check1("status", 1'b0, status_w);
        check1("done", 1'b0, done_w);
        check1("hiz", 1'b1, user_io_hiz);
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        wait_stage(ST_LOAD, 200);
        @(negedge clk);
        check1("status", 1'b1, status_w);
        check1("pullup", 1'b1, user_io_pullup);
    endtask
    // stream with init-complete pin on, oscillator timed init
    task automatic load_osc();
        wait_stage(ST_INIT, 400);
        repeat (2) @(negedge clk);
        check1("done", 1'b1, done_w);
        check1("init", 1'b0, init_w);
        repeat (OSC - 4) @(negedge clk);
        check_stage(ST_INIT);
        wait_stage(ST_USER, 8);
        check1("hiz", 1'b0, user_io_hiz);
        check1("pullup", 1'b0, user_io_pullup);
        check1("init", 1'b1, init_w);
    endtask
    // restart from user mode, status held off, start-up clock init
    task automatic reconfig_usr();
        @(posedge clk) config_req_n_in <= 1'b0;
        image <= 16'h0002;
        hold_n <= 1'b0;
        repeat (6) @(negedge clk);
        check1("status", 1'b0, status_w);
        check1("done", 1'b0, done_w);
        check1("hiz", 1'b1, user_io_hiz);
        repeat (50) @(posedge clk);
        config_req_n_in <= 1'b1;
        repeat (20) @(negedge clk);
        check1("held", 1'b0, stage === ST_LOAD);
        @(posedge clk) hold_n <= 1'b1;
        wait_stage(ST_INIT, 400);
        repeat (100) @(negedge clk);
        check_stage(ST_INIT);
        check1("init", 1'b1, init_w);
        pulse_start(298);
        repeat (4) @(negedge clk);
        check_stage(ST_INIT);
        pulse_start(1);
        wait_stage(ST_USER, 10);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        config_req_n_in = 1'b1;
        start_clk_in = 1'b0;
        hold_n = 1'b1;
        image = 16'h0001;
        failures = 0;
        compares = 0;
        power_up();
        load_osc();
        reconfig_usr();
        wrap_up();
    end
endmodule
`default_nettype wire
